// file: rtl/mmc_config.sv
// macrocell mode configuration block with its register port and feedback routing
//
// Summary of operation
// - three global modes exist: simple, complex, registered; all cells follow it.
// - sync_mode_bit and global_arch_bit together pick the mode for every cell.
// - each cell's polarity bit inverts its output, same in every mode.
// - eight polarity, eight io_config_bit and two global bits form the configuration.
// - registered mode: dedicated pins are register clock and output enable only.
// - complex mode: dedicated pins enter the array via outermost cells' feedback.
// - complex mode: outermost cells give no feedback of their own pins.
// - simple mode: each pin but the two innermost feeds back through the neighbouring cell's path.
// - simple mode: innermost cells are always outputs with no feedback path.
// - registers clear at power-on and can be preloaded for testing.
// - eight mmc_cell instances, alike but for INNER set on the two inner ones, each with own product terms.
// - registered mode: shared clock pin clocks, shared enable pin enables drivers of cells with io_config_bit clear.
// - registered cells sum eight terms; io cells sum seven plus enable term.
// - complex mode: seven terms summed, eighth drives the cell's enable.
// - simple mode: pin is input or always-enabled output of eight terms.
//
// The implementer's own choices: strobed register access and the address map.
module mmc_config #(
    parameter int unsigned NUM_CELLS = mmc_pkg::NUM_CELLS,
    parameter int unsigned NUM_PT = mmc_pkg::NUM_PT
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // register port
    input wire logic [mmc_pkg::ADDR_W-1:0] bus_addr,
    input wire logic [mmc_pkg::DATA_W-1:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [mmc_pkg::DATA_W-1:0] bus_rdata,
    // dedicated pins
    input wire logic clk_pin,
    input wire logic oe_pin_n,
    // macrocell pins
    input wire logic [NUM_CELLS-1:0] io_in,
    output logic [NUM_CELLS-1:0] io_out,
    output logic [NUM_CELLS-1:0] io_oe,
    // product terms from the array
    input wire logic [NUM_CELLS*NUM_PT-1:0] pt,
    // feedback into the array
    output logic [NUM_CELLS-1:0] fb
);

    localparam int unsigned LAST = NUM_CELLS - 1;
    localparam int unsigned HALF = NUM_CELLS / 2;

    // ==========================================
    // configuration state
    logic run;
    logic sync_mode_bit;
    logic global_arch_bit;
    logic [NUM_CELLS-1:0] pol;
    logic [NUM_CELLS-1:0] io_config_bit;
    logic [NUM_CELLS-1:0] pre_val;
    logic pre_pend;
    logic clk_pin_d;
    logic [mmc_pkg::DATA_W-1:0] rd_q;
    logic [mmc_pkg::DATA_W-1:0] rd_mux;
    mmc_pkg::mmc_mode_t mode;

    // ==========================================
    // write decode
    wire logic wr_ctrl = bus_wr && (bus_addr == mmc_pkg::OFS_CTRL);
    wire logic wr_arch = bus_wr && (bus_addr == mmc_pkg::OFS_ARCH);
    wire logic wr_pol = bus_wr && (bus_addr == mmc_pkg::OFS_POL);
    wire logic wr_iocfg = bus_wr && (bus_addr == mmc_pkg::OFS_IOCFG);
    wire logic wr_pre = bus_wr && (bus_addr == mmc_pkg::OFS_PRELOAD);
    wire logic arch_open = !run;

    // ==========================================
    // mode and shared clock pin
    assign mode = mmc_pkg::mmc_decode_mode(sync_mode_bit, global_arch_bit);

    wire logic is_simple = (mode == mmc_pkg::MMC_SIMPLE);
    wire logic is_complex = (mode == mmc_pkg::MMC_COMPLEX);
    wire logic is_registered = (mode == mmc_pkg::MMC_REGISTERED);
    wire logic pin_edge = clk_pin && !clk_pin_d;
    wire logic reg_en = pin_edge && is_registered;
    wire logic oe_act = !oe_pin_n;
    wire logic next_pre_pend = wr_pre || (pre_pend && !reg_en);

    // ==========================================
    // configuration registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            run <= mmc_pkg::RUN_RST;
            sync_mode_bit <= mmc_pkg::SYNC_RST;
            global_arch_bit <= mmc_pkg::GLOBAL_RST;
        end else begin
            if (wr_ctrl) begin
                run <= bus_wdata[mmc_pkg::CTRL_RUN_BIT];
            end
            if (wr_arch && arch_open) begin
                sync_mode_bit <= bus_wdata[mmc_pkg::ARCH_SYNC_BIT];
                global_arch_bit <= bus_wdata[mmc_pkg::ARCH_GLOBAL_BIT];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pol <= mmc_pkg::POL_RST;
            io_config_bit <= mmc_pkg::IOCFG_RST;
        end else if (arch_open) begin
            if (wr_pol) begin
                pol <= bus_wdata[NUM_CELLS-1:0];
            end
            if (wr_iocfg) begin
                io_config_bit <= bus_wdata[NUM_CELLS-1:0];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        clk_pin_d <= clk_pin; // tracks the pin in reset too: no false edge on release
        if (rst) begin
            pre_val <= mmc_pkg::PRELOAD_RST;
            pre_pend <= 1'b0;
        end else begin
            if (wr_pre) begin
                pre_val <= bus_wdata[NUM_CELLS-1:0];
            end
            pre_pend <= next_pre_pend;
        end
    end

    // ==========================================
    // eight macrocells and feedback routing
    logic [NUM_CELLS-1:0] cell_q;
    logic [NUM_CELLS-1:0] fb_own;
    logic [NUM_CELLS-1:0] simple_src;
    logic [NUM_CELLS-1:0] complex_src;
    logic [NUM_CELLS-1:0] next_fb;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CELLS; gi++) begin : g_cell
            mmc_cell #(
                .NUM_PT(NUM_PT),
                .INNER((gi == HALF - 1) || (gi == HALF))
            ) u_cell (
                .clk_sys(clk_sys),
                .rst(rst),
                .mode(mode),
                .pol(pol[gi]),
                .io_cfg(io_config_bit[gi]),
                .run(run),
                .pt(pt[gi*NUM_PT +: NUM_PT]),
                .pin_in(io_in[gi]),
                .oe_act(oe_act),
                .reg_en(reg_en),
                .preload_en(pre_pend),
                .preload_val(pre_val[gi]),
                .pin_out(io_out[gi]),
                .pin_oe(io_oe[gi]),
                .q(cell_q[gi]),
                .fb_own(fb_own[gi])
            );

            if (gi == 0) begin : g_outer_lo
                assign simple_src[gi] = clk_pin;
                assign complex_src[gi] = clk_pin;
            end else if (gi == LAST) begin : g_outer_hi
                assign simple_src[gi] = oe_pin_n;
                assign complex_src[gi] = oe_pin_n;
            end else if (gi < HALF) begin : g_upper
                assign simple_src[gi] = io_in[gi-1];
                assign complex_src[gi] = fb_own[gi];
            end else begin : g_lower
                assign simple_src[gi] = io_in[gi+1];
                assign complex_src[gi] = fb_own[gi];
            end

            assign next_fb[gi] = is_simple ? simple_src[gi] :
                                 is_complex ? complex_src[gi] : fb_own[gi];
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            fb <= '0;
        end else begin
            fb <= next_fb;
        end
    end

    // ==========================================
    // read path, data in the cycle after the strobe
    always_comb begin
        rd_mux = '0;
        if (bus_addr == mmc_pkg::OFS_CTRL) begin
            rd_mux[mmc_pkg::CTRL_RUN_BIT] = run;
        end else if (bus_addr == mmc_pkg::OFS_ARCH) begin
            rd_mux[mmc_pkg::ARCH_SYNC_BIT] = sync_mode_bit;
            rd_mux[mmc_pkg::ARCH_GLOBAL_BIT] = global_arch_bit;
        end else if (bus_addr == mmc_pkg::OFS_POL) begin
            rd_mux[NUM_CELLS-1:0] = pol;
        end else if (bus_addr == mmc_pkg::OFS_IOCFG) begin
            rd_mux[NUM_CELLS-1:0] = io_config_bit;
        end else if (bus_addr == mmc_pkg::OFS_PRELOAD) begin
            rd_mux[NUM_CELLS-1:0] = pre_val;
        end else if (bus_addr == mmc_pkg::OFS_STATUS) begin
            rd_mux[mmc_pkg::STAT_MODE_LSB +: 3] = mode;
            rd_mux[mmc_pkg::STAT_PEND_BIT] = pre_pend;
        end else if (bus_addr == mmc_pkg::OFS_REGQ) begin
            rd_mux[NUM_CELLS-1:0] = cell_q;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rd_q <= '0;
        end else if (bus_rd) begin
            rd_q <= rd_mux;
        end else begin
            rd_q <= '0;
        end
    end

    assign bus_rdata = rd_q;

    // ==========================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    property p_mode_simple;
        (sync_mode_bit && !global_arch_bit) |-> is_simple;
    endproperty
    a_mode_simple: assert property (p_mode_simple) else $error("simple code not decoded");

    property p_mode_unused;
        (!sync_mode_bit && !global_arch_bit) |-> is_registered;
    endproperty
    a_mode_unused: assert property (p_mode_unused) else $error("unused code not registered");

    property p_one_mode;
        $onehot(mode);
    endproperty
    a_one_mode: assert property (p_one_mode) else $error("mode not one of three");

    property p_arch_hold;
        (run && wr_arch) |=> $stable({sync_mode_bit, global_arch_bit});
    endproperty
    a_arch_hold: assert property (p_arch_hold) else $error("mode changed while running");

    property p_reg_pins;
        is_registered |=> (fb[0] == $past(fb_own[0])) && (fb[LAST] == $past(fb_own[LAST]));
    endproperty
    a_reg_pins: assert property (p_reg_pins) else $error("clock pin reached array");

    property p_clk_only_reg;
        reg_en |-> is_registered && $rose(clk_pin);
    endproperty
    a_clk_only_reg: assert property (p_clk_only_reg) else $error("register clock outside mode");

    property p_complex_in;
        is_complex |=> (fb[0] == $past(clk_pin)) && (fb[LAST] == $past(oe_pin_n));
    endproperty
    a_complex_in: assert property (p_complex_in) else $error("dedicated input misrouted");

    property p_simple_route;
        is_simple |=> (fb[1] == $past(io_in[0])) && (fb[HALF] == $past(io_in[HALF+1]));
    endproperty
    a_simple_route: assert property (p_simple_route) else $error("neighbour route wrong");

    property p_simple_inner;
        (is_simple && run) |=> io_oe[HALF-1] && io_oe[HALF];
    endproperty
    a_simple_inner: assert property (p_simple_inner) else $error("inner cell not driving");

    sequence s_preload_edge;
        pre_pend && reg_en;
    endsequence

    property p_preload;
        s_preload_edge |=> (cell_q == $past(pre_val));
    endproperty
    a_preload: assert property (p_preload) else $error("preload not loaded");

    property p_preload_show;
        (s_preload_edge ##1 (run && is_registered && oe_act && io_config_bit == '0))
            |=> (io_out == $past(cell_q)) && (io_oe == '1);
    endproperty
    a_preload_show: assert property (p_preload_show) else $error("preload not shown");

    property p_pend_set;
        wr_pre |=> pre_pend;
    endproperty
    a_pend_set: assert property (p_pend_set) else $error("preload write lost");

    property p_read_q;
        (bus_rd && bus_addr == mmc_pkg::OFS_REGQ) |=> (bus_rdata[NUM_CELLS-1:0] == $past(cell_q));
    endproperty
    a_read_q: assert property (p_read_q) else $error("register readback wrong");

endmodule

// file: pkg/mmc_pkg.sv
// constants, mode type and mode decode for the macrocell configuration block
package mmc_pkg;

    // ==========================================
    // sizes
    localparam int unsigned NUM_CELLS = 8;
    localparam int unsigned NUM_PT = 8;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    // ==========================================
    // register offsets (byte addresses)
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_ARCH = 8'h04;
    localparam logic [7:0] OFS_POL = 8'h08;
    localparam logic [7:0] OFS_IOCFG = 8'h0C;
    localparam logic [7:0] OFS_PRELOAD = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_REGQ = 8'h18;

    // ==========================================
    // field positions
    localparam int unsigned CTRL_RUN_BIT = 0;
    localparam int unsigned ARCH_SYNC_BIT = 0;
    localparam int unsigned ARCH_GLOBAL_BIT = 1;
    localparam int unsigned STAT_MODE_LSB = 0;
    localparam int unsigned STAT_PEND_BIT = 3;

    // ==========================================
    // reset values
    localparam logic RUN_RST = 1'b0;
    localparam logic SYNC_RST = 1'b0;
    localparam logic GLOBAL_RST = 1'b1;
    localparam logic [7:0] POL_RST = 8'h00;
    localparam logic [7:0] IOCFG_RST = 8'h00;
    localparam logic [7:0] PRELOAD_RST = 8'h00;

    // ==========================================
    // modes, one-hot
    typedef enum logic [2:0] {
        MMC_SIMPLE = 3'b001,
        MMC_COMPLEX = 3'b010,
        MMC_REGISTERED = 3'b100
    } mmc_mode_t;

    // sync=1 arch=0 simple, sync=1 arch=1 complex, otherwise registered
    function automatic mmc_mode_t mmc_decode_mode(input logic sync_bit, input logic arch_bit);
        mmc_mode_t m;
        m = MMC_REGISTERED;
        if (sync_bit && !arch_bit) begin
            m = MMC_SIMPLE;
        end else if (sync_bit && arch_bit) begin
            m = MMC_COMPLEX;
        end
        return m;
    endfunction

endpackage

// file: rtl/mmc_cell.sv
// one output macrocell: product-term sum, polarity, register and output enable
module mmc_cell #(
    parameter int unsigned NUM_PT = mmc_pkg::NUM_PT,
    parameter bit INNER = 1'b0
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // configuration
    input wire mmc_pkg::mmc_mode_t mode,
    input wire logic pol,
    input wire logic io_cfg,
    input wire logic run,
    // array, pins and register control
    input wire logic [NUM_PT-1:0] pt,
    input wire logic pin_in,
    input wire logic oe_act,
    input wire logic reg_en,
    input wire logic preload_en,
    input wire logic preload_val,
    // outputs
    output logic pin_out,
    output logic pin_oe,
    output logic q,
    output logic fb_own
);

    // ==========================================
    // sum and configuration decode
    wire logic sum_all = |pt;
    wire logic sum_seven = |pt[NUM_PT-2:0];
    wire logic pt_oe = pt[NUM_PT-1];
    wire logic is_simple = (mode == mmc_pkg::MMC_SIMPLE);
    wire logic is_reg = (mode == mmc_pkg::MMC_REGISTERED) && !io_cfg;
    wire logic is_input = is_simple && io_cfg && !INNER;
    wire logic next_q = preload_en ? preload_val : (sum_all ^ pol);
    wire logic load_q = reg_en && (is_reg || preload_en);
    wire logic comb_val = (is_simple ? sum_all : sum_seven) ^ pol;
    wire logic next_pin_out = is_reg ? q : comb_val;
    wire logic next_pin_oe = !run ? 1'b0 : is_reg ? oe_act : is_simple ? !is_input : pt_oe;

    assign fb_own = is_reg ? q : pin_in;

    // ==========================================
    // macrocell register, cleared at power-on
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            q <= 1'b0;
        end else if (load_q) begin
            q <= next_q;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pin_out <= 1'b0;
            pin_oe <= 1'b0;
        end else begin
            pin_out <= next_pin_out;
            pin_oe <= next_pin_oe;
        end
    end

    // ==========================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    property p_por_clear;
        $past(rst) |-> (q == 1'b0);
    endproperty
    a_por_clear: assert property (p_por_clear) else $error("register not cleared at reset");

    property p_reg_sum;
        (reg_en && is_reg && !preload_en) |=> (q == $past(sum_all ^ pol));
    endproperty
    a_reg_sum: assert property (p_reg_sum) else $error("register did not take sum");

    property p_complex_oe;
        (mode == mmc_pkg::MMC_COMPLEX && run) |=> (pin_oe == $past(pt_oe));
    endproperty
    a_complex_oe: assert property (p_complex_oe) else $error("complex enable mismatch");

    property p_polarity;
        (mode == mmc_pkg::MMC_COMPLEX) |=> (pin_out == $past(sum_seven ^ pol));
    endproperty
    a_polarity: assert property (p_polarity) else $error("polarity mismatch");

    property p_simple_out;
        (is_simple && run && !is_input) |=> pin_oe && (pin_out == $past(sum_all ^ pol));
    endproperty
    a_simple_out: assert property (p_simple_out) else $error("simple output wrong");

endmodule

// file: tb/mmc_board.sv
// board-side model: drives array terms, pin levels and dedicated pins
module mmc_board (
    // clock
    input wire logic clk_sys,
    // requested levels from the bench
    input wire logic [63:0] pt_v,
    input wire logic [7:0] io_v,
    input wire logic oe_v,
    input wire logic fire,
    // block's pin drivers
    input wire logic [7:0] io_out,
    input wire logic [7:0] io_oe,
    // levels seen by the block
    output logic [63:0] pt = '0,
    output logic [7:0] io_in,
    output logic clk_pin = 1'b0,
    output logic oe_pin_n = 1'b1
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] lvl = 8'h00;

    // ==========================================
    // board levels, changed only at the rising edge
    always_ff @(posedge clk_sys) begin
        pt <= pt_v;
        lvl <= io_v;
        oe_pin_n <= oe_v;
        // registered copy of fire, high as long as the request: high and low phases last at least a cycle
        clk_pin <= fire;
    end

    // wire level: the block wins where it drives, else the board level
    assign io_in = (io_oe & io_out) | (~io_oe & lvl);
endmodule

// file: tb/testbench.sv
// self-checking bench for the macrocell configuration block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [7:0] bus_addr = 8'h00;
    logic [31:0] bus_wdata = 32'h0;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [31:0] bus_rdata;
    logic [7:0] io_out, io_oe, io_in, fb;
    logic [7:0] io_v = 8'h00;
    logic [63:0] pt;
    logic [63:0] pt_v = '0;
    logic clk_pin, oe_pin_n;
    logic fire = 1'b0;
    logic oe_v = 1'b1;
    logic [7:0] q = 8'h00;
    logic [7:0] pol = 8'h00;
    logic [7:0] iocfg = 8'h00;
    int mismatches = 0;
    int compares = 0;
    int cycles = 0;

    initial forever #4 clk_sys = ~clk_sys;

    mmc_config uut (.clk_sys(clk_sys), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .clk_pin(clk_pin),
        .oe_pin_n(oe_pin_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .pt(pt), .fb(fb));

    mmc_board board (.clk_sys(clk_sys), .pt_v(pt_v), .io_v(io_v), .oe_v(oe_v), .fire(fire),
        .io_out(io_out), .io_oe(io_oe), .pt(pt), .io_in(io_in), .clk_pin(clk_pin),
        .oe_pin_n(oe_pin_n));

    // ==========================================
    // reporting
    task automatic close_out;
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            close_out();
        end
    end

    // ==========================================
    // register port cycles
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk_sys);
        bus_wr <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string name);
        @(posedge clk_sys);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk_sys);
        bus_rd <= 1'b0;
        #1 chk(name, bus_rdata, exp);
    endtask

    // one rising edge on the shared clock pin
    task automatic pulse;
        @(posedge clk_sys);
        fire <= 1'b1;
        @(posedge clk_sys);
        fire <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask

    // ==========================================
    // expectations
    function automatic logic [2:0] exp_mode(input logic [1:0] code);
        if (code == 2'b01) begin
            return 3'h1;
        end else if (code == 2'b11) begin
            return 3'h2;
        end
        return 3'h4;
    endfunction

    // returns {fb, oe, out} for settled inputs
    function automatic logic [23:0] exp_pins(input logic [2:0] m, input logic [63:0] p,
        input logic [7:0] bv, input logic cp, input logic oen);
        logic [7:0] o, e, w, f;
        for (int i = 0; i < 8; i++) begin
            if (m == 3'h1) begin
                o[i] = (|p[8*i+:8]) ^ pol[i];
                e[i] = !iocfg[i] || i == 3 || i == 4;
            end else if (m == 3'h2 || iocfg[i]) begin
                o[i] = (|p[8*i+:7]) ^ pol[i];
                e[i] = p[8*i+7];
            end else begin
                o[i] = q[i];
                e[i] = !oen;
            end
        end
        w = (e & o) | (~e & bv);
        f = w;
        if (m == 3'h4) begin
            f = (iocfg & w) | (~iocfg & q);
        end else if (m == 3'h1) begin
            f = {oen, w[7:5], w[2:0], cp};
        end else begin
            f = {oen, w[6:1], cp};
        end
        return {f, e, o};
    endfunction

    // ==========================================
    // main sequence
    initial begin
        logic [31:0] v;
        logic [1:0] code;
        logic [2:0] m;
        logic [23:0] r;
        logic cp;
        void'($urandom(70));
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        rdc(mmc_pkg::OFS_CTRL, 32'h0, "ctrl");
        rdc(mmc_pkg::OFS_ARCH, 32'h2, "arch");
        rdc(mmc_pkg::OFS_POL, 32'h0, "pol");
        rdc(mmc_pkg::OFS_IOCFG, 32'h0, "iocfg");
        rdc(mmc_pkg::OFS_PRELOAD, 32'h0, "preload");
        rdc(mmc_pkg::OFS_STATUS, 32'h4, "status");
        rdc(mmc_pkg::OFS_REGQ, 32'h0, "regq");
        rdc(8'h1C, 32'h0, "unmapped");
        chk("io_oe idle", {24'h0, io_oe}, 32'h0);
        // preload stays pending outside registered mode
        v = $urandom;
        wr(mmc_pkg::OFS_ARCH, 32'h3);
        wr(mmc_pkg::OFS_PRELOAD, {24'h0, v[7:0]});
        rdc(mmc_pkg::OFS_STATUS, 32'hA, "pending");
        pulse();
        rdc(mmc_pkg::OFS_REGQ, 32'h0, "regq held");
        wr(mmc_pkg::OFS_ARCH, 32'h2);
        oe_v <= 1'b0;
        wr(mmc_pkg::OFS_CTRL, 32'h1);
        pulse();
        rdc(mmc_pkg::OFS_REGQ, {24'h0, v[7:0]}, "regq preload");
        rdc(mmc_pkg::OFS_STATUS, 32'h4, "pending clear");
        chk("io_out preload", {24'h0, io_out}, {24'h0, v[7:0]});
        chk("io_oe preload", {24'h0, io_oe}, 32'hFF);
        q = v[7:0];
        // configuration picked per pass, every code in turn
        for (int k = 0; k < 32; k++) begin
            code = k[1:0];
            pol = 8'($urandom);
            iocfg = (k == 1) ? 8'hFF : 8'($urandom);
            wr(mmc_pkg::OFS_CTRL, 32'h0);
            wr(mmc_pkg::OFS_ARCH, {30'h0, code});
            wr(mmc_pkg::OFS_POL, {24'h0, pol});
            wr(mmc_pkg::OFS_IOCFG, {24'h0, iocfg});
            wr(mmc_pkg::OFS_CTRL, 32'h1);
            wr(mmc_pkg::OFS_ARCH, {30'h0, ~code});
            wr(mmc_pkg::OFS_POL, {24'h0, ~pol});
            wr(mmc_pkg::OFS_IOCFG, {24'h0, ~iocfg});
            m = exp_mode(code);
            rdc(mmc_pkg::OFS_STATUS, {29'h0, m}, "mode");
            rdc(mmc_pkg::OFS_POL, {24'h0, pol}, "pol held");
            rdc(mmc_pkg::OFS_IOCFG, {24'h0, iocfg}, "iocfg held");
            @(posedge clk_sys);
            pt_v <= {$urandom, $urandom} & {$urandom, $urandom} & {$urandom, $urandom};
            io_v <= 8'($urandom);
            oe_v <= 1'($urandom);
            @(posedge clk_sys);
            if (m == 3'h4) begin
                pulse();
                for (int i = 0; i < 8; i++) begin
                    if (!iocfg[i]) begin
                        q[i] = (|pt_v[8*i+:8]) ^ pol[i];
                    end
                end
                rdc(mmc_pkg::OFS_REGQ, {24'h0, q}, "regq load");
            end
            cp = (m == 3'h4) ? 1'b0 : 1'($urandom);
            fire <= cp;
            repeat (4) @(posedge clk_sys);
            #1 r = exp_pins(m, pt_v, io_v, cp, oe_v);
            chk("io_out", {24'h0, io_out & r[15:8]}, {24'h0, r[7:0] & r[15:8]});
            chk("io_oe", {24'h0, io_oe}, {24'h0, r[15:8]});
            chk("fb", {24'h0, fb}, {24'h0, r[23:16]});
            @(posedge clk_sys);
            fire <= 1'b0;
        end
        close_out();
    end
endmodule
